// ==== hdl/bus_seq_defines.vh ====
// Constants of the two-wire host bus sequence controller.
// Assumes byte-wide registers placed one per aligned 32-bit word.
// Function
// [R1] Start request with both lines high loads baud timer from reload value.
// [R2] First timeout drives SDA low only if both lines still high.
// [R3] SDA falling while SCL high sets start-seen flag.
// [R4] Second timeout clears start request, halts timer, keeps SDA low.
// [R5] Target mode: general call address with enable set raises an event; code shifts no bus bits in target mode, only a leftover zero byte fires it.
// [R6] Hardware sets ack status: one for no acknowledge, zero for acknowledge.
// [R7] Host receive ends with ack value bit sent in ack slot.
// [R8] Ack request drives ack sequence with ack value, then self-clears.
// [R9] Receive request puts port into byte receive; clear means idle.
// [R10] Stop request drives Stop condition, cleared by hardware when done.
// [R11] Restart request drives repeated Start, cleared by hardware when done.
// [R12] Target mode: start request bit enables clock stretching.
// [R13] When busy, request bits and data buffer writes are ignored.
// [R14] Software waits for request bit to clear before next request.
// [R15] Low line at request or first timeout abandons Start, flags collision.
`ifndef BUS_SEQ_DEFINES_VH
`define BUS_SEQ_DEFINES_VH
`define OFS_CONTROL 8'h00
`define OFS_RELOAD 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_DATA 8'h14
`define OFS_MODE 8'h18
`define B_START 0
`define B_RESTART 1
`define B_STOP 2
`define B_RECEIVE 3
`define B_ACKSEQ 4
`define B_ACKVAL 5
`define B_ACK_RECEIVED_STATUS 6
`define B_GENERAL_CALL_IRQ_ENABLE 7
`define CONTROL_RESET 8'h00
`define RELOAD_RESET 8'h04
`define EV_START 0
`define EV_COLL 1
`define EV_DONE 2
`define EV_GCALL 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== hdl/bus_seq_ctrl.v ====
// Host-mode bus condition controller for a two-wire port, AXI4-Lite registers.
// Assumes open-drain pads outside; scl/sda inputs are asynchronous.
`timescale 1ns/1ps
`include "bus_seq_defines.vh"
module bus_seq_ctrl (
   // Clock and reset
   input wire core_clk_in,
   input wire sys_rst_in,
   // AXI4-Lite write
   input wire [7:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   // Two-wire bus pins
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe_out,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   // Interrupt
   output reg irq_out
);
   localparam [7:0] S_IDLE = 8'h01;
   localparam [7:0] S_ST1 = 8'h02;
   localparam [7:0] S_ST2 = 8'h04;
   localparam [7:0] S_STOP = 8'h08;
   localparam [7:0] S_RS = 8'h10;
   localparam [7:0] S_RX = 8'h20;
   localparam [7:0] S_ACK = 8'h40;
   localparam [7:0] S_PH = 8'h80;

   reg [1:0] scl_s_q, sda_s_q;
   reg scl_q, sda_q, sda_prev_q;
   reg [7:0] ctrl_q, reload_q, data_q, shift_q, irq_st_q, irq_mask_q;
   reg [7:0] state_q, cnt_q;
   reg [3:0] bit_q;
   reg [1:0] phase_q;
   reg target_q, start_seen_q, drive_sda_low_q, drive_scl_low_q;
   reg [7:0] aw_q, ar_q;
   reg aw_ok_q, w_ok_q;
   reg [31:0] wd_q;
   reg [3:0] ws_q;
   reg [3:0] ev_q;

   // Pin synchronisers
   always @(posedge core_clk_in) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
      sda_prev_q <= sda_q;
   end

   function is_req;
      input [7:0] v;
      begin
         is_req = |v[`B_ACKSEQ:`B_START];
      end
   endfunction

   wire busy = (state_q != S_IDLE);
   wire start_cond = sda_prev_q & ~sda_q & scl_q;
   wire wr_go = aw_ok_q & w_ok_q & ~s_axi_bvalid_out;
   wire wr_ctl = wr_go & (aw_q == `OFS_CONTROL) & ws_q[0];
   wire tmo = (cnt_q == 8'h00);

   // Write channel capture and response
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         aw_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `RESP_OKAY;
      end else begin
         s_axi_awready_out <= ~aw_ok_q & ~s_axi_awready_out & s_axi_awvalid_in;
         s_axi_wready_out <= ~w_ok_q & ~s_axi_wready_out & s_axi_wvalid_in;
         if (s_axi_awvalid_in & s_axi_awready_out) begin
            aw_ok_q <= 1'b1;
            aw_q <= {s_axi_awaddr_in[7:2], 2'b00};
         end
         if (s_axi_wvalid_in & s_axi_wready_out) begin
            w_ok_q <= 1'b1;
            wd_q <= s_axi_wdata_in;
            ws_q <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (aw_q > `OFS_MODE) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Read channel
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `RESP_OKAY;
         ar_q <= 8'h00;
      end else begin
         s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out & s_axi_arvalid_in;
         if (s_axi_arvalid_in & s_axi_arready_out) begin
            ar_q <= {s_axi_araddr_in[7:2], 2'b00};
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= `RESP_OKAY;
            case ({s_axi_araddr_in[7:2], 2'b00})
               `OFS_CONTROL: s_axi_rdata_out <= {24'h00_0000, ctrl_q};
               `OFS_RELOAD: s_axi_rdata_out <= {24'h00_0000, reload_q};
               `OFS_STATUS: s_axi_rdata_out <= {24'h00_0000, state_q != S_IDLE, 5'h00, scl_q, start_seen_q};
               `OFS_IRQ_STATUS: s_axi_rdata_out <= {24'h00_0000, irq_st_q};
               `OFS_IRQ_MASK: s_axi_rdata_out <= {24'h00_0000, irq_mask_q};
               `OFS_DATA: s_axi_rdata_out <= {24'h00_0000, data_q};
               `OFS_MODE: s_axi_rdata_out <= {31'h0000_0000, target_q};
               default: begin
                  s_axi_rdata_out <= 32'h0000_0000;
                  s_axi_rresp_out <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // Sequencer, control register and events
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ctrl_q <= `CONTROL_RESET;
         reload_q <= `RELOAD_RESET;
         data_q <= 8'h00;
         shift_q <= 8'h00;
         irq_st_q <= 8'h00;
         irq_mask_q <= 8'h00;
         target_q <= 1'b0;
         state_q <= S_IDLE;
         cnt_q <= 8'h00;
         bit_q <= 4'h0;
         phase_q <= 2'b00;
         start_seen_q <= 1'b0;
         drive_sda_low_q <= 1'b0;
         drive_scl_low_q <= 1'b0;
         irq_out <= 1'b0;
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
         scl_out <= 1'b0;
         scl_oe_out <= 1'b0;
         ev_q <= 4'h0;
      end else begin
         ev_q <= 4'h0;
         if (start_cond) begin
            start_seen_q <= 1'b1; // see [R3]
            ev_q[`EV_START] <= 1'b1;
         end
         if (wr_go) begin
            case (aw_q)
               `OFS_CONTROL: if (ws_q[0]) begin
                  ctrl_q[`B_GENERAL_CALL_IRQ_ENABLE] <= wd_q[`B_GENERAL_CALL_IRQ_ENABLE];
                  ctrl_q[`B_ACKVAL] <= wd_q[`B_ACKVAL];
                  if (target_q)
                     ctrl_q[`B_START] <= wd_q[`B_START]; // see [R12]
                  else if (!busy && !is_req(ctrl_q))
                     ctrl_q[`B_ACKSEQ:`B_START] <= wd_q[`B_ACKSEQ:`B_START]; // see [R13]
               end
               `OFS_RELOAD: if (ws_q[0]) reload_q <= wd_q[7:0];
               `OFS_DATA: if (ws_q[0] && !busy) data_q <= wd_q[7:0]; // see [R13]
               `OFS_IRQ_MASK: if (ws_q[0]) irq_mask_q <= wd_q[7:0];
               `OFS_MODE: if (ws_q[0] && !busy) target_q <= wd_q[0];
               default: ;
            endcase
         end
         if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
         case (state_q)
            S_IDLE: begin
               if (!target_q && !wr_ctl) begin
                  if (ctrl_q[`B_START]) begin
                     if (sda_q && scl_q) begin
                        cnt_q <= reload_q; // see [R1]
                        start_seen_q <= 1'b0;
                        state_q <= S_ST1;
                     end else begin
                        ctrl_q[`B_START] <= 1'b0; // see [R15]
                        ev_q[`EV_COLL] <= 1'b1;
                     end
                  end else if (ctrl_q[`B_RESTART]) begin
                     drive_sda_low_q <= 1'b0;
                     drive_scl_low_q <= 1'b1;
                     cnt_q <= reload_q;
                     phase_q <= 2'b00;
                     state_q <= S_RS;
                  end else if (ctrl_q[`B_STOP]) begin
                     drive_sda_low_q <= 1'b1;
                     drive_scl_low_q <= 1'b1;
                     cnt_q <= reload_q;
                     phase_q <= 2'b00;
                     state_q <= S_STOP;
                  end else if (ctrl_q[`B_RECEIVE]) begin
                     drive_sda_low_q <= 1'b0; // see [R9]
                     drive_scl_low_q <= 1'b1;
                     cnt_q <= reload_q;
                     bit_q <= 4'h0;
                     state_q <= S_RX;
                  end else if (ctrl_q[`B_ACKSEQ]) begin
                     drive_sda_low_q <= ~ctrl_q[`B_ACKVAL]; // see [R7]
                     drive_scl_low_q <= 1'b1;
                     cnt_q <= reload_q;
                     phase_q <= 2'b00;
                     state_q <= S_ACK; // see [R8]
                  end else if (wr_go && aw_q == `OFS_DATA && ws_q[0]) begin
                     shift_q <= wd_q[7:0];
                     drive_sda_low_q <= ~wd_q[7];
                     drive_scl_low_q <= 1'b1;
                     cnt_q <= reload_q;
                     bit_q <= 4'h0;
                     state_q <= S_PH;
                  end
               end
            end
            S_ST1: if (tmo) begin
               if (sda_q && scl_q) begin
                  drive_sda_low_q <= 1'b1; // see [R2]
                  state_q <= S_ST2;
               end else begin
                  ctrl_q[`B_START] <= 1'b0; // see [R15]
                  ev_q[`EV_COLL] <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_ST2: if (start_seen_q && cnt_q == 8'h00 && phase_q == 2'b00) begin
               cnt_q <= reload_q; // see [R4]
               phase_q <= 2'b01;
            end else if (phase_q == 2'b01 && tmo) begin
               ctrl_q[`B_START] <= 1'b0; // see [R4]
               phase_q <= 2'b00;
               ev_q[`EV_DONE] <= 1'b1;
               state_q <= S_IDLE;
            end
            S_STOP, S_RS: if (tmo) begin
               cnt_q <= reload_q;
               phase_q <= phase_q + 2'b01;
               case (phase_q)
                  2'b00: drive_scl_low_q <= 1'b0;
                  2'b01: drive_sda_low_q <= (state_q == S_RS);
                  default: begin
                     if (state_q == S_STOP)
                        ctrl_q[`B_STOP] <= 1'b0; // see [R10]
                     else
                        ctrl_q[`B_RESTART] <= 1'b0; // see [R11]
                     ev_q[`EV_DONE] <= 1'b1;
                     state_q <= S_IDLE;
                  end
               endcase
            end
            S_RX: if (tmo) begin
               cnt_q <= reload_q;
               drive_scl_low_q <= ~drive_scl_low_q;
               if (!drive_scl_low_q) begin
                  shift_q <= {shift_q[6:0], sda_q};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) begin
                     data_q <= {shift_q[6:0], sda_q};
                     ctrl_q[`B_RECEIVE] <= 1'b0;
                     ev_q[`EV_DONE] <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_ACK: if (tmo) begin
               cnt_q <= reload_q;
               phase_q <= phase_q + 2'b01;
               case (phase_q)
                  2'b00: drive_scl_low_q <= 1'b0;
                  2'b01: drive_scl_low_q <= 1'b1;
                  default: begin
                     drive_sda_low_q <= 1'b0;
                     ctrl_q[`B_ACKSEQ] <= 1'b0; // see [R8]
                     ev_q[`EV_DONE] <= 1'b1;
                     state_q <= S_IDLE;
                  end
               endcase
            end
            S_PH: if (tmo) begin
               cnt_q <= reload_q;
               drive_scl_low_q <= ~drive_scl_low_q;
               if (!drive_scl_low_q && bit_q == 4'h8) begin
                  ctrl_q[`B_ACK_RECEIVED_STATUS] <= sda_q; // see [R6]
                  ev_q[`EV_DONE] <= 1'b1;
                  state_q <= S_IDLE;
               end else if (!drive_scl_low_q) begin
                  shift_q <= {shift_q[6:0], 1'b0};
                  drive_sda_low_q <= (bit_q != 4'h7) & ~shift_q[6];
                  bit_q <= bit_q + 4'h1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
         // Target mode general call detect in the shift register
         if (target_q && ctrl_q[`B_GENERAL_CALL_IRQ_ENABLE] && start_seen_q && shift_q == 8'h00 && bit_q == 4'h8) begin
            ev_q[`EV_GCALL] <= 1'b1; // see [R5]
            bit_q <= 4'h0;
         end
         // Set wins over write-one-to-clear
         if (wr_go && aw_q == `OFS_IRQ_STATUS && ws_q[0])
            irq_st_q <= (irq_st_q & ~wd_q[7:0]) | {4'h0, ev_q};
         else
            irq_st_q <= irq_st_q | {4'h0, ev_q};
         irq_out <= |((irq_st_q | {4'h0, ev_q}) & irq_mask_q);
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe_out <= drive_sda_low_q;
         scl_oe_out <= drive_scl_low_q | (target_q & ctrl_q[`B_START] & start_seen_q); // see [R12]
      end
   end
endmodule // bus_seq_ctrl

// ==== tb/bus_target_model.sv ====
// Far-side target model: pull-ups on both wires, optional clock stretch.
// Assumes the host drives its wires through open-drain enables.
`timescale 1ns/1ps
module bus_target_model (
   // Host enables
   input wire logic sda_oe_in,
   input wire logic scl_oe_in,
   // Stretch command
   input wire logic hold_scl_low_in,
   // Wire levels
   output logic sda_out,
   output logic scl_out
);
   // Released wires float high through pull-ups
   assign sda_out = !sda_oe_in;
   assign scl_out = !(scl_oe_in | hold_scl_low_in);
endmodule // bus_target_model

// ==== tb/bus_seq_ctrl_asserts.sv ====
// Checker for the bus sequence controller ports.
// Assumes it is bound into the controller's top module.
`timescale 1ns/1ps
module bus_seq_ctrl_asserts (
   // Clock and reset
   input wire core_clk_in,
   input wire sys_rst_in,
   // Register bus answers
   input wire [1:0] s_axi_bresp_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [31:0] s_axi_rdata_out,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   // Wires
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe_out,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_out,
   // Interrupt
   input wire irq_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   AST_RESET_QUIET: assert property ($fell(sys_rst_in) |-> !sda_oe_out && !scl_oe_out && !irq_out)
      else $error("outputs active after reset");
   AST_PINS_OPEN_DRAIN: assert property (!sda_out && !scl_out)
      else $error("wire driven high");
   AST_START_NEEDS_HIGH: assert property ($rose(sda_oe_out) && !scl_oe_out |-> $past(sda_in, 3) && $past(scl_in, 3))
      else $error("start driven on busy wires");
   AST_START_HOLDS_LOW: assert property ($rose(sda_oe_out) && !scl_oe_out |=> sda_oe_out [*3])
      else $error("start not held low");
   AST_BVALID_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write response dropped");
   AST_RVALID_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rdata_out))
      else $error("read data changed");
   AST_RDATA_UPPER: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   AST_BRESP_CODE: assert property (s_axi_bvalid_out |-> !s_axi_bresp_out[0])
      else $error("bad write response");
endmodule // bus_seq_ctrl_asserts
bind bus_seq_ctrl bus_seq_ctrl_asserts u_chk (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the bus sequence controller.
// Assumes the target model supplies wire levels with pull-ups.
`timescale 1ns/1ps
module tb;
   logic core_clk_in = 0, sys_rst_in = 1, hold_scl = 0;
   logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
   logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, d;
   logic [3:0] s_axi_wstrb_in = 4'h1;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
   logic scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out;
   wire scl_in, sda_in;
   int fails = 0, checked = 0;
   bus_seq_ctrl dut (.*);
   bus_target_model u_tgt (.sda_oe_in(sda_oe_out), .scl_oe_in(scl_oe_out), .hold_scl_low_in(hold_scl),
      .sda_out(sda_in), .scl_out(scl_in));
   always #5 core_clk_in = ~core_clk_in;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit b;
      @(posedge core_clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= v;
      s_axi_awvalid_in <= 1;
      s_axi_wvalid_in <= 1;
      s_axi_bready_in <= 1;
      while (!b) begin
         @(posedge core_clk_in);
         if (s_axi_awready_out && s_axi_awvalid_in) s_axi_awvalid_in <= 0;
         if (s_axi_wready_out && s_axi_wvalid_in) s_axi_wvalid_in <= 0;
         if (s_axi_bvalid_out) begin
            b = 1;
            r = s_axi_bresp_out;
         end
      end
      s_axi_bready_in <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      bit g;
      @(posedge core_clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1;
      s_axi_rready_in <= 1;
      while (!g) begin
         @(posedge core_clk_in);
         if (s_axi_arready_out && s_axi_arvalid_in) s_axi_arvalid_in <= 0;
         if (s_axi_rvalid_out) begin
            g = 1;
            d = s_axi_rdata_out;
            r = s_axi_rresp_out;
         end
      end
      s_axi_rready_in <= 0;
   endtask
   // Poll control until the given request bits self-clear
   task automatic wait_clear(input logic [7:0] m);
      for (int n = 0; n < 300; n++) begin
         rd(8'h00);
         if ((d[7:0] & m) == 8'h00) break;
      end
      chk("request self-clear", 32'h0000_0000, d & {24'h00_0000, m});
   endtask
   task automatic t_reset_map;
      rd(8'h00);
      chk("control reset", 32'h0000_0000, d);
      rd(8'h04);
      chk("reload reset", 32'h0000_0004, d);
      rd(8'h1C);
      chk("unmapped data", 32'h0000_0000, d);
      chk("unmapped resp", 32'h0000_0002, {30'h0, r});
   endtask
   task automatic t_start_busy;
      wr(8'h04, 32'h0000_00FF);
      wr(8'h10, 32'h0000_000F);
      wr(8'h00, 32'h0000_0001);
      wr(8'h00, 32'h0000_0005);
      rd(8'h00);
      chk("stop while busy", 32'h0000_0000, d & 32'h0000_0004);
      wait_clear(8'h01);
      chk("sda held low", 32'h0000_0001, {31'h0, sda_oe_out});
      chk("scl released", 32'h0000_0000, {31'h0, scl_oe_out});
      rd(8'h08);
      chk("start seen", 32'h0000_0001, d & 32'h0000_0001);
      chk("irq raised", 32'h0000_0001, {31'h0, irq_out});
      wr(8'h0C, 32'h0000_000F);
      repeat (3) @(posedge core_clk_in);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq_out});
   endtask
   task automatic t_sequences;
      logic [7:0] codes[4] = '{8'h02, 8'h30, 8'h08, 8'h04};
      wr(8'h04, 32'h0000_0003);
      wr(8'h10, 32'h0000_0000);
      foreach (codes[i]) begin
         wr(8'h00, {24'h00_0000, codes[i]});
         wait_clear(codes[i] & 8'h1F);
         chk("irq masked", 32'h0000_0000, {31'h0, irq_out});
         if (codes[i] == 8'h08) begin
            rd(8'h14);
            chk("received byte", 32'h0000_00FF, d);
         end
      end
      chk("sda after stop", 32'h0000_0000, {31'h0, sda_oe_out});
      chk("scl after stop", 32'h0000_0000, {31'h0, scl_oe_out});
      rd(8'h0C);
      chk("done event", 32'h0000_0004, d & 32'h0000_0004);
   endtask
   task automatic t_collision;
      hold_scl <= 1;
      wr(8'h00, 32'h0000_0001);
      wait_clear(8'h01);
      chk("no start driven", 32'h0000_0000, {31'h0, sda_oe_out});
      rd(8'h0C);
      chk("collision event", 32'h0000_0002, d & 32'h0000_0002);
      hold_scl <= 0;
   endtask
   // Target mode: start request bit acts as clock stretch enable
   task automatic t_stretch;
      wr(8'h18, 32'h0000_0001);
      wr(8'h00, 32'h0000_0001);
      repeat (2) @(posedge core_clk_in);
      chk("stretch on", 32'h0000_0001, {31'h0, scl_oe_out});
      wr(8'h00, 32'h0000_0000);
      repeat (2) @(posedge core_clk_in);
      chk("stretch off", 32'h0000_0000, {31'h0, scl_oe_out});
      wr(8'h18, 32'h0000_0000);
   endtask
   // Host transmit of one byte; nobody pulls the ack slot low
   task automatic t_transmit;
      wr(8'h14, 32'h0000_00A5);
      wr(8'h14, 32'h0000_003C);
      rd(8'h14);
      chk("data write while busy", 32'h0000_00A5, d);
      for (int n = 0; n < 300; n++) begin
         rd(8'h08);
         if (!d[7]) break;
      end
      chk("transmit finished", 32'h0000_0000, d & 32'h0000_0080);
      rd(8'h00);
      chk("ack status", 32'h0000_0040, d & 32'h0000_0040);
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk_in);
      sys_rst_in <= 0;
      t_reset_map();
      t_start_busy();
      t_sequences();
      t_collision();
      t_stretch();
      t_transmit();
      tally_and_finish();
   end
   initial begin
      repeat (60000) @(posedge core_clk_in);
      fails++;
      tally_and_finish();
   end
endmodule // tb
